// file: rtl/pcac_regs.sv
/*
 * Charge pump and VCO auto-calibration configuration bank, AHB-Lite slave.
 * Assumes single word transfers, one clock, and that the transfer request
 * and phase detector pulses come from logic on hclk.
 */
// Function
// - sink gain bits 6:0, 20 uA steps, reset 100
// - source gain bits 13:7, 20 uA steps, reset 100
// - offset magnitude bits 20:14, 5 uA steps
// - offset up bit 21, down bit 22
// - bit 23 selects high current pump
// - measurement length code maps to divider cycles
// - curve temperature offset, signed curve count
// - wait states at startup and after measurements
// - approximation depth eight down to five bits
// - tuning skip bit 11, force curve bit 10
// - bit 12 suppresses oscillator link transfers
// - calibration clock divides reference by 1/4/16/32
// - bit 15 selects falling crystal edge
// - polarity invert swaps source and sink pulses
`timescale 1ns/10ps
module pcac_regs #(
    parameter int ADDR_W = 8,
    parameter int CNT_W = 8
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Charge pump controls.
    output logic [6:0] pump_sink_gain,
    output logic [6:0] pump_source_gain,
    output logic [6:0] offset_magnitude,
    output logic offset_source_on,
    output logic offset_sink_on,
    output logic high_current_pump,
    output logic [11:0] sink_current_ua,
    output logic [11:0] source_current_ua,
    output logic [9:0] offset_current_ua,
    // Auto-calibration controls.
    output logic [8:0] meas_cycles,
    output logic signed [3:0] curve_temp_offset,
    output logic [1:0] wait_after_cycles,
    output logic [6:0] wait_length,
    output logic [3:0] approximation_depth,
    output logic force_curve,
    output logic tuning_skip,
    output logic [5:0] calibration_clock_divider,
    output logic calibration_negedge_select,
    output logic ref_divider_skip,
    output logic [6:0] cal_spare_bits,
    // Oscillator link trigger.
    input wire logic vco_access_wr,
    output logic vco_xfer_start,
    // Phase detector steering.
    input wire logic pd_up_raw,
    input wire logic pd_dn_raw,
    output logic detector_polarity_invert,
    output logic pump_source_pulse,
    output logic pump_sink_pulse
);
    logic [23:0] cp_reg_r;
    logic [23:0] cal_reg_r;
    logic [23:0] det_reg_r;
    logic [23:0] cp_nxt;
    logic [23:0] cal_nxt;
    logic [23:0] det_nxt;
    logic [CNT_W-1:0] blocked_cnt_r;
    logic [CNT_W-1:0] issued_cnt_r;
    logic [CNT_W-1:0] blocked_nxt;
    logic [CNT_W-1:0] issued_nxt;
    logic dp_wr_r;
    logic [5:0] dp_idx_r;
    logic [5:0] ap_idx;
    logic ap_take;
    logic wr_now;
    logic [31:0] rd_val;

    pcac_cfg_if cfg ();

    // ------------------------------------------------------------
    // Bus slave.
    // ------------------------------------------------------------
    assign ap_take = hsel && hready && htrans[1];
    assign ap_idx = haddr[7:2];
    assign wr_now = dp_wr_r;

    // Address phase: remember a word write for its data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_r <= 1'b0;
            dp_idx_r <= 6'h00;
        end else if (hready) begin
            dp_wr_r <= ap_take && hwrite && (hsize == pcac_pkg::HSIZE_WORD);
            dp_idx_r <= ap_idx;
        end
    end

    // Next register values; a read in the cycle after a write sees it.
    always_comb begin
        cp_nxt = cp_reg_r;
        cal_nxt = cal_reg_r;
        det_nxt = det_reg_r;
        if (wr_now && dp_idx_r == pcac_pkg::CP_IDX) begin
            cp_nxt = hwdata[23:0];
        end
        if (wr_now && dp_idx_r == pcac_pkg::CAL_IDX) begin
            cal_nxt = hwdata[23:0];
        end
        if (wr_now && dp_idx_r == pcac_pkg::DET_IDX) begin
            det_nxt = {23'h000000, hwdata[pcac_pkg::DET_INV_BIT]};
        end
    end

    // Each request advances one transfer counter: the blocked count if blocked, else the issued count.
    assign blocked_nxt = blocked_cnt_r + CNT_W'(vco_access_wr &&
        cal_reg_r[pcac_pkg::BLOCK_BIT]);
    assign issued_nxt = issued_cnt_r + CNT_W'(vco_access_wr &&
        !cal_reg_r[pcac_pkg::BLOCK_BIT]);

    // Read mux; unmapped words read as zero.
    always_comb begin
        rd_val = 32'h00000000;
        case (ap_idx)
            pcac_pkg::CP_IDX: rd_val = {8'h00, cp_nxt};
            pcac_pkg::CAL_IDX: rd_val = {8'h00, cal_nxt};
            pcac_pkg::DET_IDX: rd_val = {8'h00, det_nxt};
            pcac_pkg::STAT_IDX: begin
                rd_val[CNT_W-1:0] = blocked_nxt;
                rd_val[2*CNT_W-1:CNT_W] = issued_nxt;
            end
            default: rd_val = 32'h00000000;
        endcase
    end

    // Read data is latched at the address phase so it stands all data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (ap_take && !hwrite) begin
            hrdata <= rd_val;
        end
    end

    // Zero wait states and always OKAY.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Register storage.
    // ------------------------------------------------------------
    // Charge pump and calibration words keep all 24 bits, the detector word keeps bit 0 only; calibration bits 23:17 go out on cal_spare_bits.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cp_reg_r <= pcac_pkg::CP_RESET;
            cal_reg_r <= pcac_pkg::CAL_RESET;
            det_reg_r <= pcac_pkg::DET_RESET;
        end else begin
            cp_reg_r <= cp_nxt;
            cal_reg_r <= cal_nxt;
            det_reg_r <= det_nxt;
        end
    end

    // Status counters wrap; software reads differences, not absolutes.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            blocked_cnt_r <= '0;
            issued_cnt_r <= '0;
        end else begin
            blocked_cnt_r <= blocked_nxt;
            issued_cnt_r <= issued_nxt;
        end
    end

    assign cfg.cp_reg = cp_reg_r;
    assign cfg.cal_reg = cal_reg_r;

    pcac_decode u_decode (
        .cfg(cfg)
    );

    // ------------------------------------------------------------
    // Charge pump outputs.
    // ------------------------------------------------------------
    // Raw fields and scaled currents, one register stage after storage.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pump_sink_gain <= 7'h00;
            pump_source_gain <= 7'h00;
            offset_magnitude <= 7'h00;
            offset_source_on <= 1'b0;
            offset_sink_on <= 1'b0;
            high_current_pump <= 1'b0;
            sink_current_ua <= 12'h000;
            source_current_ua <= 12'h000;
            offset_current_ua <= 10'h000;
        end else begin
            pump_sink_gain <= cp_reg_r[pcac_pkg::SINK_LSB +: 7];
            pump_source_gain <= cp_reg_r[pcac_pkg::SOURCE_LSB +: 7];
            offset_magnitude <= cp_reg_r[pcac_pkg::OFFS_LSB +: 7];
            offset_source_on <= cp_reg_r[pcac_pkg::OFFS_UP_BIT];
            offset_sink_on <= cp_reg_r[pcac_pkg::OFFS_DN_BIT];
            high_current_pump <= cp_reg_r[pcac_pkg::HIGH_CUR_BIT];
            sink_current_ua <= cfg.sink_ua;
            source_current_ua <= cfg.source_ua;
            offset_current_ua <= cfg.offset_ua;
        end
    end

    // ------------------------------------------------------------
    // Calibration outputs.
    // ------------------------------------------------------------
    // Decoded calibration settings; the outputs lag storage by one cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meas_cycles <= 9'h000;
            curve_temp_offset <= 4'sh0;
            wait_after_cycles <= 2'h0;
            wait_length <= 7'h00;
            approximation_depth <= 4'h0;
            force_curve <= 1'b0;
            tuning_skip <= 1'b0;
            calibration_clock_divider <= 6'h00;
            calibration_negedge_select <= 1'b0;
            ref_divider_skip <= 1'b0;
            cal_spare_bits <= 7'h00;
        end else begin
            meas_cycles <= cfg.meas_cycles;
            curve_temp_offset <= cfg.curve_off;
            wait_after_cycles <= cal_reg_r[pcac_pkg::WAIT_LSB +: 2];
            wait_length <= pcac_pkg::WAIT_TFSM;
            approximation_depth <= cfg.sar_bits;
            force_curve <= cal_reg_r[pcac_pkg::FORCE_BIT];
            tuning_skip <= cal_reg_r[pcac_pkg::SKIP_BIT];
            calibration_clock_divider <= cfg.clk_div;
            calibration_negedge_select <=
                cal_reg_r[pcac_pkg::NEGEDGE_BIT];
            ref_divider_skip <= cal_reg_r[pcac_pkg::RSKIP_BIT];
            cal_spare_bits <= cal_reg_r[23:17];
        end
    end

    // ------------------------------------------------------------
    // Link trigger and detector steering.
    // ------------------------------------------------------------
    // A blocked request is dropped, not queued, so it is never replayed.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vco_xfer_start <= 1'b0;
        end else begin
            vco_xfer_start <= vco_access_wr &&
                !cal_reg_r[pcac_pkg::BLOCK_BIT];
        end
    end

    // Inverted polarity exchanges the pump pulse roles.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            detector_polarity_invert <= 1'b0;
            pump_source_pulse <= 1'b0;
            pump_sink_pulse <= 1'b0;
        end else begin
            detector_polarity_invert <= det_reg_r[pcac_pkg::DET_INV_BIT];
            if (det_reg_r[pcac_pkg::DET_INV_BIT]) begin
                pump_source_pulse <= pd_dn_raw;
                pump_sink_pulse <= pd_up_raw;
            end else begin
                pump_source_pulse <= pd_up_raw;
                pump_sink_pulse <= pd_dn_raw;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic first_cyc_r;
    // Marks the first edge after reset release for the reset checks.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            first_cyc_r <= 1'b1;
        end else begin
            first_cyc_r <= 1'b0;
        end
    end

    reset_words_a: assert property (first_cyc_r |->
        cp_reg_r == pcac_pkg::CP_RESET && cal_reg_r == pcac_pkg::CAL_RESET)
        else $error("register words not at reset value");
    sink_gain_a: assert property (
        wr_now && dp_idx_r == pcac_pkg::CP_IDX |->
        ##2 pump_sink_gain == $past(hwdata[6:0], 2)
        && sink_current_ua == 12'($past(hwdata[6:0], 2)) * 12'd20)
        else $error("sink gain does not follow write");
    source_gain_a: assert property (
        wr_now && dp_idx_r == pcac_pkg::CP_IDX |->
        ##2 pump_source_gain == $past(hwdata[13:7], 2))
        else $error("source gain does not follow write");
    meas_len_a: assert property (
        $past(cal_reg_r[2:0]) == 3'h4 |-> meas_cycles == 9'h020)
        else $error("measurement length code 4 not 32");
    curve_neg_a: assert property (
        $past(cal_reg_r[5:3]) == 3'h4 |-> curve_temp_offset == -4'sd4)
        else $error("curve code 4 not minus four");
    wait_count_a: assert property (
        $past(cal_reg_r[7:6]) == 2'h2 |-> wait_after_cycles == 2'h2
        && wait_length == 7'h64)
        else $error("wait setup mismatch");
    sar_depth_a: assert property (
        $past(cal_reg_r[9:8]) == 2'h0 |-> approximation_depth == 4'h8)
        else $error("depth code 0 not eight bits");
    link_block_a: assert property (
        vco_access_wr |=> vco_xfer_start == !$past(cal_reg_r[12]))
        else $error("oscillator transfer gating wrong");
    clk_div_a: assert property (
        $past(cal_reg_r[14:13]) == 2'h3 |-> calibration_clock_divider == 6'h20)
        else $error("clock select 3 not divide by 32");
    pol_swap_a: assert property (
        det_reg_r[0] && pd_up_raw |=> pump_sink_pulse)
        else $error("inverted polarity did not swap");
    rskip_a: assert property (
        wr_now && dp_idx_r == pcac_pkg::CAL_IDX |->
        ##2 ref_divider_skip == $past(hwdata[16], 2))
        else $error("divider skip does not follow write");

    cp_write_c: cover property (wr_now && dp_idx_r == pcac_pkg::CP_IDX);
    cal_read_c: cover property (ap_take && !hwrite &&
        ap_idx == pcac_pkg::CAL_IDX);
    blocked_c: cover property (vco_access_wr && cal_reg_r[12]);
    swapped_c: cover property (det_reg_r[0] && pd_dn_raw);
endmodule

// file: pkg/pcac_pkg.sv
/*
 * Constants for the charge pump and auto-calibration config bank.
 * Assumes a 32-bit AHB-Lite slave with one aligned word per register.
 */
package pcac_pkg;
    // ------------------------------------------------------------
    // Register indices (byte address is four times the index).
    // ------------------------------------------------------------
    localparam logic [5:0] CP_IDX = 6'h09;
    localparam logic [5:0] CAL_IDX = 6'h0a;
    localparam logic [5:0] DET_IDX = 6'h10;
    localparam logic [5:0] STAT_IDX = 6'h11;
    localparam int REG_W = 24;

    // ------------------------------------------------------------
    // Reset values.
    // ------------------------------------------------------------
    localparam logic [23:0] CP_RESET = 24'h403264;
    localparam logic [23:0] CAL_RESET = 24'h002205;
    localparam logic [23:0] DET_RESET = 24'h000000;

    // ------------------------------------------------------------
    // Field positions, charge pump register.
    // ------------------------------------------------------------
    localparam int SINK_LSB = 0;
    localparam int SOURCE_LSB = 7;
    localparam int OFFS_LSB = 14;
    localparam int GAIN_W = 7;
    localparam int OFFS_UP_BIT = 21;
    localparam int OFFS_DN_BIT = 22;
    localparam int HIGH_CUR_BIT = 23;

    // ------------------------------------------------------------
    // Field positions, calibration and detector registers.
    // ------------------------------------------------------------
    localparam int VRES_LSB = 0;
    localparam int CURVE_LSB = 3;
    localparam int WAIT_LSB = 6;
    localparam int SAR_LSB = 8;
    localparam int FORCE_BIT = 10;
    localparam int SKIP_BIT = 11;
    localparam int BLOCK_BIT = 12;
    localparam int CDIV_LSB = 13;
    localparam int NEGEDGE_BIT = 15;
    localparam int RSKIP_BIT = 16;
    localparam int DET_INV_BIT = 0;

    // ------------------------------------------------------------
    // Scaling and timing figures.
    // ------------------------------------------------------------
    localparam logic [11:0] GAIN_STEP_UA = 12'h014;
    localparam logic [9:0] OFFS_STEP_UA = 10'h005;
    localparam logic [6:0] WAIT_TFSM = 7'h64;
    localparam logic [3:0] SAR_MAX_BITS = 4'h8;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// file: pkg/pcac_cfg_if.sv
/*
 * Carrier between the register bank and its field decoder.
 * Assumes both ends sit on the same clock; the decoder is combinational.
 */
`timescale 1ns/10ps
interface pcac_cfg_if;
    logic [23:0] cp_reg;
    logic [23:0] cal_reg;
    logic [11:0] sink_ua;
    logic [11:0] source_ua;
    logic [9:0] offset_ua;
    logic [8:0] meas_cycles;
    logic signed [3:0] curve_off;
    logic [3:0] sar_bits;
    logic [5:0] clk_div;

    modport bank (output cp_reg, cal_reg, input sink_ua, source_ua,
        offset_ua, meas_cycles, curve_off, sar_bits, clk_div);
    modport dec (input cp_reg, cal_reg, output sink_ua, source_ua,
        offset_ua, meas_cycles, curve_off, sar_bits, clk_div);
endinterface

// file: rtl/pcac_decode.sv
/*
 * Field decoder: turns stored codes into currents, counts and ratios.
 * Assumes the bank registers every result before it leaves the block.
 */
`timescale 1ns/10ps
module pcac_decode (
    // Raw codes in, decoded values out.
    pcac_cfg_if.dec cfg
);
    logic [6:0] sink_code;
    logic [6:0] source_code;
    logic [6:0] offs_code;
    logic [2:0] curve_code;

    // ------------------------------------------------------------
    // Current scaling.
    // ------------------------------------------------------------
    assign sink_code = cfg.cp_reg[pcac_pkg::SINK_LSB +: pcac_pkg::GAIN_W];
    assign source_code =
        cfg.cp_reg[pcac_pkg::SOURCE_LSB +: pcac_pkg::GAIN_W];
    assign offs_code = cfg.cp_reg[pcac_pkg::OFFS_LSB +: pcac_pkg::GAIN_W];
    // Products fit: 127 * 20 = 2540 and 127 * 5 = 635.
    assign cfg.sink_ua = {5'h00, sink_code} * pcac_pkg::GAIN_STEP_UA;
    assign cfg.source_ua =
        {5'h00, source_code} * pcac_pkg::GAIN_STEP_UA;
    assign cfg.offset_ua =
        {3'h0, offs_code} * pcac_pkg::OFFS_STEP_UA;

    // Curve offset: codes 4 to 7 read as two's complement -4 to -1.
    assign curve_code = cfg.cal_reg[pcac_pkg::CURVE_LSB +: 3];
    assign cfg.curve_off = {curve_code[2], curve_code};

    // ------------------------------------------------------------
    // Measurement length, depth and clock ratio.
    // ------------------------------------------------------------
    // Measurement length skips 16, so it is a table, not a shift.
    always_comb begin
        case (cfg.cal_reg[pcac_pkg::VRES_LSB +: 3])
            3'h0: cfg.meas_cycles = 9'h001;
            3'h1: cfg.meas_cycles = 9'h002;
            3'h2: cfg.meas_cycles = 9'h004;
            3'h3: cfg.meas_cycles = 9'h008;
            3'h4: cfg.meas_cycles = 9'h020;
            3'h5: cfg.meas_cycles = 9'h040;
            3'h6: cfg.meas_cycles = 9'h080;
            default: cfg.meas_cycles = 9'h100;
        endcase
    end

    // Approximation depth counts down from eight bits.
    assign cfg.sar_bits = pcac_pkg::SAR_MAX_BITS -
        {2'h0, cfg.cal_reg[pcac_pkg::SAR_LSB +: 2]};

    // Calibration clock ratio from the crystal reference.
    always_comb begin
        case (cfg.cal_reg[pcac_pkg::CDIV_LSB +: 2])
            2'h0: cfg.clk_div = 6'h01;
            2'h1: cfg.clk_div = 6'h04;
            2'h2: cfg.clk_div = 6'h10;
            default: cfg.clk_div = 6'h20;
        endcase
    end
endmodule

// file: sim/pcac_regs_tb.sv
/*
 * Self-checking bench for the charge pump and calibration config bank.
 * Assumes the zero-wait AHB-Lite slave and the port timing of the bank.
 */
`timescale 1ns/10ps
module pcac_regs_tb;
    // ------------------------------------------------------------
    // Signals and design instance.
    // ------------------------------------------------------------
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, q;
    logic vco_access_wr = 1'b0, pd_up_raw = 1'b0, pd_dn_raw = 1'b0;
    logic hreadyout, hresp, offset_source_on, offset_sink_on;
    logic high_current_pump, force_curve, tuning_skip;
    logic calibration_negedge_select, ref_divider_skip, vco_xfer_start;
    logic detector_polarity_invert, pump_source_pulse, pump_sink_pulse;
    logic [31:0] hrdata;
    logic [6:0] pump_sink_gain, pump_source_gain, offset_magnitude;
    logic [6:0] wait_length, cal_spare_bits;
    logic [11:0] sink_current_ua, source_current_ua;
    logic [9:0] offset_current_ua;
    logic [8:0] meas_cycles;
    logic signed [3:0] curve_temp_offset;
    logic [1:0] wait_after_cycles;
    logic [3:0] approximation_depth;
    logic [5:0] calibration_clock_divider;
    int num_errors = 0, checked = 0;

    // The single slave's ready is the bus ready.
    pcac_regs pcac_regs_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .pump_sink_gain(pump_sink_gain),
        .pump_source_gain(pump_source_gain),
        .offset_magnitude(offset_magnitude),
        .offset_source_on(offset_source_on), .offset_sink_on(offset_sink_on),
        .high_current_pump(high_current_pump),
        .sink_current_ua(sink_current_ua),
        .source_current_ua(source_current_ua),
        .offset_current_ua(offset_current_ua), .meas_cycles(meas_cycles),
        .curve_temp_offset(curve_temp_offset),
        .wait_after_cycles(wait_after_cycles), .wait_length(wait_length),
        .approximation_depth(approximation_depth),
        .force_curve(force_curve), .tuning_skip(tuning_skip),
        .calibration_clock_divider(calibration_clock_divider),
        .calibration_negedge_select(calibration_negedge_select),
        .ref_divider_skip(ref_divider_skip), .cal_spare_bits(cal_spare_bits),
        .vco_access_wr(vco_access_wr), .vco_xfer_start(vco_xfer_start),
        .pd_up_raw(pd_up_raw), .pd_dn_raw(pd_dn_raw),
        .detector_polarity_invert(detector_polarity_invert),
        .pump_source_pulse(pump_source_pulse),
        .pump_sink_pulse(pump_sink_pulse));

    // ------------------------------------------------------------
    // Shared tasks.
    // ------------------------------------------------------------
    // Case inequality so that an unknown never passes for a match.
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One single transfer; waits on ready, only the watchdog ends a wait.
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [2:0] sz, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= sz;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    // Decoded outputs land one edge after the data phase; two spare edges.
    task automatic settle();
        repeat (3) @(posedge hclk);
        #1;
    endtask

    // ------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------
    task automatic t_reset();
        bus(1'b0, 8'h24, 32'h0, 3'h2, q);
        chk("cp reset", 32'h00403264, q);
        bus(1'b0, 8'h28, 32'h0, 3'h2, q);
        chk("cal reset", 32'h00002205, q);
        chk("sink ua", 32'd2000, {20'h0, sink_current_ua});
        chk("src", 32'd100, {25'h0, pump_source_gain});
        chk("meas", 32'd64, {23'h0, meas_cycles});
        chk("depth", 32'd6, {28'h0, approximation_depth});
        chk("cdiv", 32'd4, {26'h0, calibration_clock_divider});
        chk("sink on", 32'h1, {31'h0, offset_sink_on});
    endtask

    // Extreme gain codes; the top byte is written as ones and must read 0.
    task automatic t_cp();
        bus(1'b1, 8'h24, 32'hffdfc07f, 3'h2, q);
        settle();
        chk("sink", 32'd127, {25'h0, pump_sink_gain});
        chk("src offs", 32'h7f, {18'h0, pump_source_gain,
            offset_magnitude});
        chk("sink ua", 32'd2540, {20'h0, sink_current_ua});
        chk("src ua", 32'd0, {20'h0, source_current_ua});
        chk("offs ua", 32'd635, {22'h0, offset_current_ua});
        chk("offs", 32'h6, {29'h0, high_current_pump, offset_sink_on,
            offset_source_on});
        bus(1'b0, 8'h24, 32'h0, 3'h2, q);
        chk("cp read", 32'h00dfc07f, q);
    endtask

    // Every code of the mapped calibration fields, bit 12 kept clear.
    task automatic t_cal();
        int m[8] = '{1, 2, 4, 8, 32, 64, 128, 256};
        int v[4] = '{1, 4, 16, 32};
        logic [31:0] d;
        for (int i = 0; i < 8; i++) begin
            d = i | (i << 3) | ((i & 3) << 6) | ((i & 3) << 8) |
                ((i & 1) << 10) | (((i >> 1) & 1) << 11) | ((i & 3) << 13) |
                ((i >> 2) << 15) | ((i & 1) << 16) | ((7'h55 ^ i) << 17);
            bus(1'b1, 8'h28, d, 3'h2, q);
            settle();
            chk("meas", m[i], {23'h0, meas_cycles});
            chk("curve", (i < 4) ? i : i + 8,
                {28'h0, curve_temp_offset});
            chk("wait", i & 3, {30'h0, wait_after_cycles});
            chk("wait len", 32'd100, {25'h0, wait_length});
            chk("depth", 8 - (i & 3), {28'h0, approximation_depth});
            chk("skips", {d[16], d[15], d[11:10]}, {28'h0, ref_divider_skip,
                calibration_negedge_select, tuning_skip,
                force_curve});
            chk("cdiv", v[i & 3], {26'h0, calibration_clock_divider});
            chk("spare", d[23:17], {25'h0, cal_spare_bits});
            bus(1'b0, 8'h28, 32'h0, 3'h2, q);
            chk("cal read", d, q);
        end
    endtask

    // One passed and one blocked oscillator link request, then the counts.
    task automatic link(input logic exp);
        @(posedge hclk);
        vco_access_wr <= 1'b1;
        @(posedge hclk);
        vco_access_wr <= 1'b0;
        #1;
        chk("xfer", {31'h0, exp}, {31'h0, vco_xfer_start});
    endtask
    task automatic t_link();
        bus(1'b1, 8'h28, 32'h00002205, 3'h2, q);
        settle();
        link(1'b1);
        bus(1'b1, 8'h28, 32'h00003205, 3'h2, q);
        settle();
        link(1'b0);
        bus(1'b0, 8'h44, 32'h0, 3'h2, q);
        chk("stat", 32'h00000101, q);
    endtask

    // Raw up or down pulse; inverted polarity swaps the pump roles.
    task automatic pulse(input logic inv, input logic up);
        @(posedge hclk);
        pd_up_raw <= up;
        pd_dn_raw <= !up;
        @(posedge hclk);
        pd_up_raw <= 1'b0;
        pd_dn_raw <= 1'b0;
        #1;
        chk("pulses", {30'h0, !(up ^ inv), up ^ inv}, {30'h0,
            pump_sink_pulse, pump_source_pulse});
    endtask
    task automatic t_det();
        pulse(1'b0, 1'b1);
        pulse(1'b0, 1'b0);
        bus(1'b1, 8'h40, 32'h1, 3'h2, q);
        settle();
        chk("inv", 32'h1, {31'h0, detector_polarity_invert});
        pulse(1'b1, 1'b1);
        pulse(1'b1, 1'b0);
    endtask

    // Halfword writes are dropped and unmapped places read 0.
    task automatic t_refuse();
        bus(1'b1, 8'h24, 32'h0, 3'h1, q);
        bus(1'b0, 8'h24, 32'h0, 3'h2, q);
        chk("cp kept", 32'h00dfc07f, q);
        bus(1'b1, 8'h30, 32'hffffffff, 3'h2, q);
        bus(1'b0, 8'h30, 32'h0, 3'h2, q);
        chk("unmapped", 32'h0, q);
    endtask

    // ------------------------------------------------------------
    // Clock, sequence, watchdog and verdict.
    // ------------------------------------------------------------
    initial begin
        forever #25 hclk = ~hclk;
    end

    task automatic close_out();
        if (num_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        #1;
        t_reset();
        t_cp();
        t_cal();
        t_link();
        t_det();
        t_refuse();
        close_out();
    end

    // The run needs some 150 cycles; twenty times that is ample.
    initial begin
        #150000;
        num_errors++;
        close_out();
    end
endmodule
